/* File: rtl/tslp_pkg.sv */
// Purpose: constants for the time-slot led pulse timing block
// Assumes: 25 MHz clock, 16-bit registers on a byte-wide address port
// Notes:   offsets are register indices on the device register port
// Summary of operation
// - pulse width field, microseconds, resets to three
// - offset before first pulse, microseconds, resets 0x20
// - pulse count per slot, resets to eight
// - ten-bit period, high bits in register channel_powerdown_period_high
// - slot b light off suppresses its pulses
// - slot a light off suppresses its pulses
// - light off never stops the slot timing
// - three power-down bits for channels three, four
// - three power-down bits for channel two
// - cathode select bit, 1.3 V or 1.8 V
// - override enable clears cathode_global_used, cathode_high still follows global cathode select
package tslp_pkg;
    // clock rate and microsecond step
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned STEP_US       = 1;
    localparam int unsigned CYC_PER_US    = (CLK_HZ / 1_000_000) * STEP_US;
    localparam logic [4:0]  US_LAST       = 5'(CYC_PER_US - 1);
    // register indices
    localparam logic [7:0]  A_SHAPE_ADR   = 8'h30;
    localparam logic [7:0]  A_TRAIN_ADR   = 8'h31;
    localparam logic [7:0]  LED_DIS_ADR   = 8'h34;
    localparam logic [7:0]  B_SHAPE_ADR   = 8'h35;
    localparam logic [7:0]  B_TRAIN_ADR   = 8'h36;
    localparam logic [7:0]  PD_PER_ADR    = 8'h37;
    localparam logic [7:0]  AFE_CFG_ADR   = 8'h3c;
    // reset values
    localparam logic [15:0] SHAPE_RST     = 16'h0320;
    localparam logic [15:0] TRAIN_RST     = 16'h0818;
    localparam logic [15:0] LED_DIS_RST   = 16'h0000;
    localparam logic [15:0] PD_PER_RST    = 16'h0000;
    localparam logic [15:0] AFE_CFG_RST   = 16'h3000;
    // field positions
    localparam int unsigned WID_LSB       = 8;
    localparam int unsigned WID_MSB       = 12;
    localparam int unsigned OFF_MSB       = 7;
    localparam int unsigned CNT_LSB       = 8;
    localparam int unsigned CNT_MSB       = 15;
    localparam int unsigned PER_LO_MSB    = 7;
    localparam int unsigned A_PER_HI_LSB  = 0;
    localparam int unsigned B_PER_HI_LSB  = 8;
    localparam int unsigned A_DIS_BIT     = 8;
    localparam int unsigned B_DIS_BIT     = 9;
    localparam int unsigned PD_LSB        = 10;
    localparam int unsigned PD_MSB        = 15;
    localparam int unsigned CATHODE_BIT   = 9;
    // slot sequencer states
    typedef enum logic [1:0] {TSLP_IDLE, TSLP_OFFSET, TSLP_TRAIN} tslp_state_e;
endpackage : tslp_pkg

/* File: rtl/tslp_top.sv */
// Purpose: per-slot led pulse train generator with afe configuration bits
// Assumes: register port and slot starts come from logic on clk
// Notes:   read data appears one cycle after the address
module tslp_top
    import tslp_pkg::*;
(
    input  wire logic        clk,                 // 25 MHz time base
    input  wire logic        resetn,              // async reset, active low
    input  wire logic [7:0]  reg_addr,            // register index
    input  wire logic        reg_wr,              // write strobe
    input  wire logic [15:0] reg_wdata,           // write data
    output logic      [15:0] reg_rdata,           // registered read data
    input  wire logic        slot_a_start,        // slot a begins (pulse)
    input  wire logic        slot_b_start,        // slot b begins (pulse)
    input  wire logic        cathode_override_enable, // per-mode cathode in use
    output logic             slot_a_busy,         // slot a sequence running
    output logic             slot_b_busy,         // slot b sequence running
    output logic             led_a_drive,         // slot a led current pulse
    output logic             led_b_drive,         // slot b led current pulse
    output logic      [2:0]  second_channel_powerdown, // ch2 transimpedance, bandpass, integrator
    output logic      [2:0]  upper_channels_powerdown, // ch3/4 transimpedance, bandpass, integrator
    output logic             cathode_high,        // 1: 1.8 V, 0: 1.3 V
    output logic             cathode_global_used  // global select in force
);
    // register file
    logic [15:0] a_shape_ff;              // slot a width and offset
    logic [15:0] a_train_ff;              // slot a count and period lsbs
    logic [15:0] led_dis_ff;              // light off bits
    logic [15:0] b_shape_ff;              // slot b width and offset
    logic [15:0] b_train_ff;              // slot b count and period lsbs
    logic [15:0] pd_per_ff;               // power-down and period msbs
    logic [15:0] afe_cfg_ff;              // global afe configuration
    logic [15:0] rdata_ff;                // read data holding flop
    logic        cath_high_ff;            // global cathode select level, not changed by override
    logic        cath_glob_ff;            // global bit in force
    logic        led_ff [2];              // led drive per slot
    // per-slot sequencer
    tslp_state_e state_ff [2];            // slot state
    logic        busy_ff  [2];            // slot running, kept as a flop for the port
    logic [4:0]  us_ff    [2];            // cycles within the microsecond
    logic [9:0]  tmr_ff   [2];            // microseconds within phase
    logic [7:0]  sent_ff  [2];            // pulses issued so far

    // decoded fields per slot
    wire logic [4:0] width   [2];
    wire logic [7:0] offset  [2];
    wire logic [7:0] count   [2];
    wire logic [9:0] period  [2];
    wire logic       dark    [2];
    wire logic       start   [2];
    wire logic       us_tick [2];
    wire logic [15:0] rd_mux;

    assign width[0]  = a_shape_ff[WID_MSB:WID_LSB];
    assign width[1]  = b_shape_ff[WID_MSB:WID_LSB];
    assign offset[0] = a_shape_ff[OFF_MSB:0];
    assign offset[1] = b_shape_ff[OFF_MSB:0];
    assign count[0]  = a_train_ff[CNT_MSB:CNT_LSB];
    assign count[1]  = b_train_ff[CNT_MSB:CNT_LSB];
    assign period[0] = {pd_per_ff[A_PER_HI_LSB+1:A_PER_HI_LSB], a_train_ff[PER_LO_MSB:0]};
    assign period[1] = {pd_per_ff[B_PER_HI_LSB+1:B_PER_HI_LSB], b_train_ff[PER_LO_MSB:0]};
    assign dark[0]   = led_dis_ff[A_DIS_BIT];
    assign dark[1]   = led_dis_ff[B_DIS_BIT];
    assign start[0]  = slot_a_start;
    assign start[1]  = slot_b_start;
    assign us_tick[0] = (us_ff[0] == US_LAST);
    assign us_tick[1] = (us_ff[1] == US_LAST);

    // read decode, unmapped indices read zero
    assign rd_mux = (reg_addr == A_SHAPE_ADR) ? a_shape_ff :
                    (reg_addr == A_TRAIN_ADR) ? a_train_ff :
                    (reg_addr == LED_DIS_ADR) ? led_dis_ff :
                    (reg_addr == B_SHAPE_ADR) ? b_shape_ff :
                    (reg_addr == B_TRAIN_ADR) ? b_train_ff :
                    (reg_addr == PD_PER_ADR)  ? pd_per_ff  :
                    (reg_addr == AFE_CFG_ADR) ? afe_cfg_ff : 16'h0000;

    // register writes
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            a_shape_ff <= SHAPE_RST;
            a_train_ff <= TRAIN_RST;
            led_dis_ff <= LED_DIS_RST;
            b_shape_ff <= SHAPE_RST;
            b_train_ff <= TRAIN_RST;
            pd_per_ff  <= PD_PER_RST;
            afe_cfg_ff <= AFE_CFG_RST;
        end
        else if (reg_wr)
        begin
            // whole word stored at the selected index
            case (reg_addr)
                A_SHAPE_ADR: a_shape_ff <= reg_wdata;
                A_TRAIN_ADR: a_train_ff <= reg_wdata;
                LED_DIS_ADR: led_dis_ff <= reg_wdata;
                B_SHAPE_ADR: b_shape_ff <= reg_wdata;
                B_TRAIN_ADR: b_train_ff <= reg_wdata;
                PD_PER_ADR:  pd_per_ff  <= reg_wdata;
                AFE_CFG_ADR: afe_cfg_ff <= reg_wdata;
                default:     ;
            endcase
        end
    end

    // read data and cathode selection flops
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_ff     <= 16'h0000;
            cath_high_ff <= 1'b0;
            cath_glob_ff <= 1'b1;
        end
        else
        begin
            rdata_ff     <= rd_mux;
            cath_high_ff <= afe_cfg_ff[CATHODE_BIT];
            cath_glob_ff <= !cathode_override_enable;
        end
    end

    // slot sequencers, one per time slot
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int s = 0; s < 2; s++)
            begin
                state_ff[s] <= TSLP_IDLE;
                us_ff[s]    <= 5'h00;
                tmr_ff[s]   <= 10'h000;
                sent_ff[s]  <= 8'h00;
                led_ff[s]   <= 1'b0;
                busy_ff[s]  <= 1'b0;
            end
        end
        else
        begin
            for (int s = 0; s < 2; s++)
            begin
                // microsecond prescaler, held at zero while idle, so each accepted slot start begins a fresh microsecond
                us_ff[s] <= (us_tick[s] || state_ff[s] == TSLP_IDLE) ? 5'h00 : us_ff[s] + 5'h01;
                // light off does not affect sequencing
                case (state_ff[s])
                    TSLP_IDLE:
                    begin
                        // a start while running is ignored
                        if (start[s])
                        begin
                            state_ff[s] <= TSLP_OFFSET;
                            busy_ff[s]  <= 1'b1;
                            tmr_ff[s]   <= 10'h000;
                            sent_ff[s]  <= 8'h00;
                        end
                    end
                    TSLP_OFFSET:
                    begin
                        if ({2'b00, offset[s]} == tmr_ff[s])
                        begin
                            state_ff[s] <= (count[s] == 8'h00) ? TSLP_IDLE : TSLP_TRAIN;
                            // busy falls together with the return to idle
                            busy_ff[s]  <= (count[s] != 8'h00);
                            tmr_ff[s]   <= 10'h000;
                            sent_ff[s]  <= (count[s] == 8'h00) ? 8'h00 : 8'h01;
                        end
                        else if (us_tick[s])
                        begin
                            tmr_ff[s] <= tmr_ff[s] + 10'h001;
                        end
                    end
                    TSLP_TRAIN:
                    begin
                        if (us_tick[s])
                        begin
                            if (tmr_ff[s] + 10'h001 >= period[s])
                            begin
                                tmr_ff[s] <= 10'h000;
                                if (sent_ff[s] == count[s])
                                begin
                                    state_ff[s] <= TSLP_IDLE;
                                    busy_ff[s]  <= 1'b0;
                                end
                                else
                                begin
                                    sent_ff[s] <= sent_ff[s] + 8'h01;
                                end
                            end
                            else
                            begin
                                tmr_ff[s] <= tmr_ff[s] + 10'h001;
                            end
                        end
                    end
                    default:
                    begin
                        // unreachable code, recover to idle
                        state_ff[s] <= TSLP_IDLE;
                        busy_ff[s]  <= 1'b0;
                    end
                endcase
                // led on for width microseconds of each period
                led_ff[s] <= (state_ff[s] == TSLP_TRAIN) && (tmr_ff[s] < {5'h00, width[s]})
                             && !(us_tick[s] && tmr_ff[s] + 10'h001 >= period[s]
                                  && sent_ff[s] == count[s])
                             && !dark[s];
            end
        end
    end

    // output map, all straight from flops
    assign reg_rdata                = rdata_ff;
    assign slot_a_busy              = busy_ff[0];
    assign slot_b_busy              = busy_ff[1];
    assign led_a_drive              = led_ff[0];
    assign led_b_drive              = led_ff[1];
    assign second_channel_powerdown = pd_per_ff[PD_LSB+2:PD_LSB];
    assign upper_channels_powerdown = pd_per_ff[PD_MSB:PD_LSB+3];
    assign cathode_high             = cath_high_ff;
    assign cathode_global_used      = cath_glob_ff;
endmodule // tslp_top

/* File: testbench/tslp_chk.sv */
// Purpose: port-level assertions for tslp_top
// Assumes: one clock, resetn async active low
// Notes:   bound from tb_top, watches ports only
module tslp_chk
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        slot_a_start,
    input wire logic        slot_a_busy,
    input wire logic        slot_b_busy,
    input wire logic        led_a_drive,
    input wire logic        led_b_drive,
    input wire logic        cathode_override_enable,
    input wire logic [2:0]  second_channel_powerdown,
    input wire logic [2:0]  upper_channels_powerdown,
    input wire logic        cathode_high,
    input wire logic        cathode_global_used
);
    timeunit 1ns;
    timeprecision 1ps;
    // one domain, so clock and disable are shared
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // no led pulse once a slot has been idle a while
    property p_led_a_idle; !slot_a_busy [*3] |-> !led_a_drive; endproperty
    a_led_a_idle: assert property (p_led_a_idle) else $error("led a on while idle");
    property p_led_b_idle; !slot_b_busy [*3] |-> !led_b_drive; endproperty
    a_led_b_idle: assert property (p_led_b_idle) else $error("led b on while idle");
    // power-down outputs follow writes to channel_powerdown_period_high
    property p_pd_ch2; reg_wr && reg_addr == 8'h37 |=> second_channel_powerdown == $past(reg_wdata[12:10]);
    endproperty
    a_pd_ch2: assert property (p_pd_ch2) else $error("ch2 power-down wrong");
    property p_pd_ch34; reg_wr && reg_addr == 8'h37 |=> upper_channels_powerdown == $past(reg_wdata[15:13]);
    endproperty
    a_pd_ch34: assert property (p_pd_ch34) else $error("ch3/4 power-down wrong");
    // cathode select lags its register by one cycle
    property p_cath; reg_wr && reg_addr == 8'h3c |=> ##1 cathode_high == $past(reg_wdata[9], 2); endproperty
    a_cath: assert property (p_cath) else $error("cathode select wrong");
    property p_glob; $changed(cathode_override_enable) |=> cathode_global_used == !$past(cathode_override_enable);
    endproperty
    a_glob: assert property (p_glob) else $error("global cathode flag wrong");
    // unmapped indices read zero
    property p_rd_unm; !(reg_addr inside {8'h30, 8'h31, 8'h34, 8'h35, 8'h36, 8'h37, 8'h3c}) |=> reg_rdata == 16'h0000;
    endproperty
    a_rd_unm: assert property (p_rd_unm) else $error("unmapped read not zero");
    property p_busy_a; slot_a_start && !slot_a_busy |=> slot_a_busy [*8]; endproperty
    a_busy_a: assert property (p_busy_a) else $error("slot a did not start");
endmodule // tslp_chk

/* File: testbench/tb_top.sv */
// Purpose: register and pulse-train tests for tslp_top
// Assumes: 25 MHz clock, inputs driven at falling edge
// Notes:   pulse timing checked as cycle counts with small slack
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, reg_wr, slot_a_start, slot_b_start, cathode_override_enable;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic slot_a_busy, slot_b_busy, led_a_drive, led_b_drive, cathode_high, cathode_global_used;
    logic [2:0]  second_channel_powerdown, upper_channels_powerdown;
    int error_cnt = 0, comparisons = 0, cyc = 0, bc, lc;
    tslp_top tslp_top_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .slot_a_start(slot_a_start),
        .slot_b_start(slot_b_start), .cathode_override_enable(cathode_override_enable),
        .slot_a_busy(slot_a_busy), .slot_b_busy(slot_b_busy), .led_a_drive(led_a_drive),
        .led_b_drive(led_b_drive), .second_channel_powerdown(second_channel_powerdown),
        .upper_channels_powerdown(upper_channels_powerdown), .cathode_high(cathode_high),
        .cathode_global_used(cathode_global_used));
    // counts and verdict, single exit point
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rng(input string nm, input int lo, input int hi, input int g);
        comparisons++;
        if (g < lo || g > hi)
        begin
            error_cnt++;
            $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wr = 1'b1;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        chk("reg_rdata", e, reg_rdata);
    endtask
    // start one slot, count busy cycles and led cycles
    task automatic run(input logic b, input int busy_us, input int led_cyc);
        bc = 0;
        lc = 0;
        @(negedge clk);
        slot_a_start = !b;
        slot_b_start = b;
        @(negedge clk);
        slot_a_start = 1'b0;
        slot_b_start = 1'b0;
        while ((b ? slot_b_busy : slot_a_busy) === 1'b1 && bc < 8000)
        begin
            bc++;
            lc += int'((b ? led_b_drive : led_a_drive) === 1'b1);
            @(negedge clk);
        end
        rng("busy cycles", busy_us * 25 - 5, busy_us * 25 + 5, bc);
        rng("led cycles", led_cyc - 4, led_cyc + 4, lc);
        $display("test slot run done");
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            end_sim();
        end
    end
    initial
    begin
        {resetn, reg_wr, slot_a_start, slot_b_start, cathode_override_enable} = '0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        rd(8'h30, 16'h0320);
        rd(8'h35, 16'h0320);
        rd(8'h31, 16'h0818);
        rd(8'h36, 16'h0818);
        rd(8'h34, 16'h0000);
        rd(8'h37, 16'h0000);
        rd(8'h3c, 16'h3000);
        wr(8'h32, 16'hffff);
        rd(8'h32, 16'h0000);
        $display("test reset values done");
        wr(8'h37, 16'h6800);
        rd(8'h37, 16'h6800);
        chk("upper_pd", 16'(3'b011), 16'(upper_channels_powerdown));
        chk("second_pd", 16'(3'b010), 16'(second_channel_powerdown));
        wr(8'h3c, 16'h3200);
        rd(8'h3c, 16'h3200);
        chk("cathode_high", 16'h0001, 16'(cathode_high));
        cathode_override_enable = 1'b1;
        rd(8'h3c, 16'h3200);
        chk("cathode_global_used", 16'h0000, 16'(cathode_global_used));
        cathode_override_enable = 1'b0;
        rd(8'h3c, 16'h3200);
        chk("cathode_global_used", 16'h0001, 16'(cathode_global_used));
        $display("test afe config done");
        wr(8'h37, 16'h0000);
        wr(8'h30, 16'h0102);
        wr(8'h31, 16'h0203);
        run(1'b0, 8, 50);
        wr(8'h34, 16'h0200);
        wr(8'h35, 16'h0102);
        wr(8'h36, 16'h0203);
        run(1'b1, 8, 0);
        wr(8'h34, 16'h0300);
        run(1'b0, 8, 0);
        run(1'b1, 8, 0);
        wr(8'h34, 16'h0000);
        wr(8'h31, 16'h0100);
        wr(8'h37, 16'h0001);
        run(1'b0, 258, 25);
        end_sim();
    end
endmodule // tb_top
bind tslp_top tslp_chk tslp_chk_i (.clk, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
    .slot_a_start, .slot_a_busy, .slot_b_busy, .led_a_drive, .led_b_drive, .cathode_override_enable,
    .second_channel_powerdown, .upper_channels_powerdown, .cathode_high, .cathode_global_used);
